// file: pmd_defines.svh
// Constants for the privileged mode dispatch unit: opcodes, entry offsets,
// internal register indices and reset values. Included by the decoder, selector, unit and testbench.
`ifndef PMD_DEFINES_SVH
`define PMD_DEFINES_SVH

// Primary opcode field, bits 31:26
`define PMD_OP_CALL 6'h00
`define PMD_OP_MFPR 6'h19
`define PMD_OP_LD 6'h1B
`define PMD_OP_MTPR 6'h1D
`define PMD_OP_REI 6'h1E
`define PMD_OP_ST 6'h1F

// Entry offsets, low 14 bits of the dispatch address
`define PMD_OFF_RESET 14'h0000
`define PMD_OFF_MACHINE_CHECK_ENTRY 14'h0020
`define PMD_OFF_ARITH 14'h0060
`define PMD_OFF_INTR 14'h00E0
`define PMD_OFF_DFAULT 14'h01E0
`define PMD_OFF_ITB_MISS 14'h03E0
`define PMD_OFF_DTB_MISS 14'h09E0
`define PMD_OFF_ILLEGAL_OPCODE_TRAP 14'h13E0
`define PMD_OFF_CALL_PRIV 14'h2000
`define PMD_OFF_CALL_USER 14'h3000

// Internal register select: group bit and index
`define PMD_IPR_IBX_BIT 5
`define PMD_IPR_EXCEPTION_RETURN_ADDRESS 5'h04
`define PMD_IPR_BASE 5'h0B

// Reset values and fixed steps
`define PMD_BASE_RST 20'h0_0000
`define PMD_EXC_RST 34'h0_0000_0000
`define PMD_CALL_STEP 34'h0_0000_0004

`endif

// file: pmd_pkg.sv
// Types shared by the privileged mode dispatch unit.
// Assumes pmd_defines.svh for all numeric constants.
`default_nettype none
package pmd_pkg;

  typedef enum logic [1:0] {
    PMD_ST_RESET = 2'b00,
    PMD_ST_RUN = 2'b01,
    PMD_ST_DRAIN = 2'b10,
    PMD_ST_DISP = 2'b11
  } pmd_state_t;

  // Event bit positions, highest priority first
  typedef enum logic [2:0] {
    PMD_EV_MACHINE_CHECK_ENTRY = 3'h0,
    PMD_EV_ARITH = 3'h1,
    PMD_EV_INTR = 3'h2,
    PMD_EV_DFAULT = 3'h3,
    PMD_EV_ITB = 3'h4,
    PMD_EV_DTB = 3'h5
  } pmd_event_t;

  typedef struct packed {
    pmd_state_t state;
    logic privileged_code_mode;
    logic map_en;
    logic intr_en;
    logic [33:0] exception_return_address;
    logic [19:0] privileged_code_base;
    logic [5:0] pend;
    logic [13:0] off;
    logic [33:0] save_pc;
    logic from_instr;
    logic drain;
    logic redirect;
    logic [33:0] redirect_pc;
    logic trap;
    logic unmapped;
    logic [63:0] rdata;
    logic ready;
  } pmd_regs_t;

endpackage
`default_nettype wire

// file: pmd_decode.sv
// Instruction decoder for the privileged mode dispatch unit.
// Purely combinational; the caller qualifies results with its valid.
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defines.svh"

module pmd_decode (
  // Instruction word
  input wire logic [31:0] instr,
  // Decoded class
  output logic is_mfpr,
  output logic is_mtpr,
  output logic is_ld,
  output logic is_st,
  output logic is_rei,
  output logic is_hw,
  output logic is_call,
  output logic call_priv,
  output logic call_ok,
  output logic [13:0] call_off
);
  logic [5:0] op;
  logic [25:0] func;

  always_comb begin
    op = instr[31:26];
    func = instr[25:0];
    is_mfpr = (op == `PMD_OP_MFPR);
    is_mtpr = (op == `PMD_OP_MTPR);
    is_ld = (op == `PMD_OP_LD);
    is_st = (op == `PMD_OP_ST);
    is_rei = (op == `PMD_OP_REI);
    is_hw = is_mfpr | is_mtpr | is_ld | is_st | is_rei;
    is_call = (op == `PMD_OP_CALL); // RL16
    // Functions 00-3F are privileged, 80-BF unprivileged
    call_priv = ~func[7];
    call_ok = (func[25:8] == 18'h0_0000) && ~func[6]; // RL18
    call_off = (func[7] ? `PMD_OFF_CALL_USER : `PMD_OFF_CALL_PRIV)
             | {2'b00, func[5:0], 6'h00};
  end
endmodule
`default_nettype wire

// file: pmd_prio.sv
// Fixed-priority selector over pending hardware events.
// Returns a one-hot grant and the entry offset of the winner.
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defines.svh"

module pmd_prio
  import pmd_pkg::*;
(
  // Pending events
  input wire logic [5:0] pend,
  // Winner
  output logic [5:0] grant,
  output logic [13:0] off
);
  always_comb begin
    grant = 6'h00;
    off = `PMD_OFF_MACHINE_CHECK_ENTRY;
    if (pend[PMD_EV_MACHINE_CHECK_ENTRY]) begin
      grant[PMD_EV_MACHINE_CHECK_ENTRY] = 1'b1;
      off = `PMD_OFF_MACHINE_CHECK_ENTRY;
    end else if (pend[PMD_EV_ARITH]) begin
      grant[PMD_EV_ARITH] = 1'b1;
      off = `PMD_OFF_ARITH;
    end else if (pend[PMD_EV_INTR]) begin
      grant[PMD_EV_INTR] = 1'b1;
      off = `PMD_OFF_INTR;
    end else if (pend[PMD_EV_DFAULT]) begin
      grant[PMD_EV_DFAULT] = 1'b1;
      off = `PMD_OFF_DFAULT;
    end else if (pend[PMD_EV_ITB]) begin
      grant[PMD_EV_ITB] = 1'b1;
      off = `PMD_OFF_ITB_MISS;
    end else if (pend[PMD_EV_DTB]) begin
      grant[PMD_EV_DTB] = 1'b1;
      off = `PMD_OFF_DTB_MISS;
    end
  end
endmodule
`default_nettype wire

// file: pmd_unit.sv
// Privileged mode dispatch unit: enters and leaves privileged code mode,
// dispatches events and call instructions, handles the return instruction.
// Assumes the pipeline holds INSTR_VALID until INSTR_READY and drains on DRAIN_REQ.
//
// Functional notes
// (RL1) Privileged mode turns off instruction fetch address mapping.
// (RL2) Privileged mode holds off all interrupts.
// (RL3) Five privileged-only instructions outside the mode raise illegal opcode trap.
// (RL4) Register moves access internal registers; special load/store skip translation.
// (RL5) Dispatch address is an entry offset added to a programmable base.
// (RL6) On dispatch: drain pipeline, save PC, then jump and enter privileged mode.
// (RL7) Return instruction jumps to the saved exception address.
// (RL8) Saved address bit 0 set keeps privileged mode, clear leaves it.
// (RL9) Leaving on return re-enables interrupts and mapping, resumes normal execution.
// (RL10) Reset enters privileged mode at reset routine until return with bit clear.
// (RL11) Machine check, arithmetic, decode and data fetch errors dispatch by type.
// (RL12) A sensed interrupt dispatches to the interrupt routine.
// (RL13) Data or instruction translation miss dispatches to its own fill routine.
// (RL14) Call instruction uses the same drain, save and dispatch steps.
// (RL15) Call instruction saves its own address plus four.
// (RL16) Call opcode in bits 31:26, routine select in bits 25:0.
// (RL17) Privileged call outside kernel mode goes to illegal opcode entry 13E0.
// (RL18) Call with unsupported function code takes the illegal opcode trap.
// (RL19) Every dispatched call runs its routine in privileged mode.
// (RL20) Return target is saved address with low two bits cleared.
// (RL21) Dispatch address: base bits 33:14, offset bits 13:0; base resets to zero.
// (RL22) Simultaneous causes: serve highest, hold others until the routine returns.
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defines.svh"

module pmd_unit
  import pmd_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Hardware events, one-cycle pulses or levels
  input wire logic EVT_MACHINE_CHECK_ENTRY,
  input wire logic EVT_ARITH,
  input wire logic EVT_INTR,
  input wire logic EVT_DFAULT,
  input wire logic EVT_ITB_MISS,
  input wire logic EVT_DTB_MISS,
  // Pipeline state
  input wire logic [33:0] CUR_PC,
  input wire logic PIPE_EMPTY,
  input wire logic KERNEL_MODE,
  // Instruction offered for dispatch checks
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [33:0] INSTR_PC,
  input wire logic [63:0] IPR_WDATA,
  output logic INSTR_READY,
  // Mode controls
  output logic PRIV_MODE,
  output logic FETCH_MAP_EN,
  output logic INTR_ENABLE,
  output logic DRAIN_REQ,
  // Fetch redirect
  output logic REDIRECT_VALID,
  output logic [33:0] REDIRECT_PC,
  // Instruction side effects
  output logic TRAP_ILLEGAL_OPCODE_TRAP,
  output logic UNMAPPED_ACCESS,
  output logic [63:0] IPR_RDATA
);
  pmd_regs_t r;
  pmd_regs_t next_r;

  logic is_mfpr, is_mtpr, is_ld, is_st, is_rei, is_hw;
  logic is_call, call_priv, call_ok;
  logic [13:0] call_off;
  logic [5:0] grant;
  logic [13:0] ev_off;
  logic [5:0] events;
  logic take_evt;
  logic acc;
  logic illegal;
  logic ibx_exc;
  logic ibx_base;

  pmd_decode u_dec (
    .instr(INSTR_WORD),
    .is_mfpr(is_mfpr),
    .is_mtpr(is_mtpr),
    .is_ld(is_ld),
    .is_st(is_st),
    .is_rei(is_rei),
    .is_hw(is_hw),
    .is_call(is_call),
    .call_priv(call_priv),
    .call_ok(call_ok),
    .call_off(call_off)
  );

  pmd_prio u_prio (
    .pend(r.pend),
    .grant(grant),
    .off(ev_off)
  );

  // Dispatch address from base and entry offset
  function automatic logic [33:0] disp_addr(input logic [19:0] base, input logic [13:0] off);
    disp_addr = {base, off}; // RL5 RL21
  endfunction

  always_comb begin
    events = 6'h00;
    events[PMD_EV_MACHINE_CHECK_ENTRY] = EVT_MACHINE_CHECK_ENTRY; // RL11
    events[PMD_EV_ARITH] = EVT_ARITH; // RL11
    events[PMD_EV_INTR] = EVT_INTR; // RL12
    events[PMD_EV_DFAULT] = EVT_DFAULT; // RL11
    events[PMD_EV_ITB] = EVT_ITB_MISS; // RL13
    events[PMD_EV_DTB] = EVT_DTB_MISS; // RL13
    // Causes only taken outside the mode, so others wait for the return
    take_evt = (r.state == PMD_ST_RUN) && !r.privileged_code_mode && (r.pend != 6'h00); // RL2 RL22
    acc = (r.state == PMD_ST_RUN) && INSTR_VALID && r.ready && !take_evt;
    illegal = (is_hw && !r.privileged_code_mode) // RL3
            || (is_call && !call_ok) // RL18
            || (is_call && call_priv && !KERNEL_MODE && !r.privileged_code_mode); // RL17
    ibx_exc = INSTR_WORD[`PMD_IPR_IBX_BIT] && (INSTR_WORD[4:0] == `PMD_IPR_EXCEPTION_RETURN_ADDRESS);
    ibx_base = INSTR_WORD[`PMD_IPR_IBX_BIT] && (INSTR_WORD[4:0] == `PMD_IPR_BASE);

    next_r = r;
    next_r.redirect = 1'b0;
    next_r.trap = 1'b0;
    next_r.unmapped = 1'b0;

    case (r.state)
      PMD_ST_RESET: begin
        next_r.privileged_code_mode = 1'b1; // RL10
        next_r.redirect = 1'b1;
        next_r.redirect_pc = disp_addr(r.privileged_code_base, `PMD_OFF_RESET); // RL10
        next_r.state = PMD_ST_RUN;
      end
      PMD_ST_RUN: begin
        if (take_evt) begin
          next_r.off = ev_off;
          next_r.pend = r.pend & ~grant; // RL22
          next_r.from_instr = 1'b0;
          next_r.drain = 1'b1; // RL6
          next_r.state = PMD_ST_DRAIN;
        end else if (acc && illegal) begin
          next_r.off = `PMD_OFF_ILLEGAL_OPCODE_TRAP; // RL3 RL17 RL18
          next_r.save_pc = INSTR_PC;
          next_r.from_instr = 1'b1;
          next_r.trap = 1'b1;
          next_r.drain = 1'b1;
          next_r.state = PMD_ST_DRAIN;
        end else if (acc && is_call) begin
          next_r.off = call_off; // RL14 RL16
          next_r.save_pc = INSTR_PC + `PMD_CALL_STEP; // RL15
          next_r.from_instr = 1'b1;
          next_r.drain = 1'b1; // RL14
          next_r.state = PMD_ST_DRAIN;
        end else if (acc && is_rei) begin
          next_r.redirect = 1'b1; // RL7
          next_r.redirect_pc = {r.exception_return_address[33:2], 2'b00}; // RL20
          next_r.privileged_code_mode = r.exception_return_address[0]; // RL8 RL9
        end else if (acc && is_mtpr) begin
          if (ibx_exc) begin
            next_r.exception_return_address = IPR_WDATA[33:0]; // RL4
          end else if (ibx_base) begin
            next_r.privileged_code_base = IPR_WDATA[33:14]; // RL4
          end
        end else if (acc && is_mfpr) begin
          if (ibx_exc) begin
            next_r.rdata = {30'h0000_0000, r.exception_return_address}; // RL4
          end else if (ibx_base) begin
            next_r.rdata = {30'h0000_0000, r.privileged_code_base, 14'h0000};
          end else begin
            next_r.rdata = 64'h0000_0000_0000_0000;
          end
        end else if (acc && (is_ld || is_st)) begin
          next_r.unmapped = 1'b1; // RL4
        end
      end
      PMD_ST_DRAIN: begin
        // Save only once the pipeline is empty
        if (PIPE_EMPTY) begin
          next_r.exception_return_address = r.from_instr ? r.save_pc : CUR_PC; // RL6
          next_r.drain = 1'b0;
          next_r.state = PMD_ST_DISP;
        end
      end
      PMD_ST_DISP: begin
        next_r.redirect = 1'b1;
        next_r.redirect_pc = disp_addr(r.privileged_code_base, r.off); // RL5 RL6
        next_r.privileged_code_mode = 1'b1; // RL6 RL19
        next_r.state = PMD_ST_RUN;
      end
      default: begin
        next_r.state = PMD_ST_RESET;
      end
    endcase

    // Set wins over the clear of a granted bit
    next_r.pend = next_r.pend | events; // RL22
    next_r.map_en = !next_r.privileged_code_mode; // RL1 RL9
    next_r.intr_en = !next_r.privileged_code_mode; // RL2 RL9
    // Stall instructions while a cause waits to be taken
    next_r.ready = (next_r.state == PMD_ST_RUN)
                 && !(!next_r.privileged_code_mode && (next_r.pend != 6'h00));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r.state <= PMD_ST_RESET;
      r.privileged_code_mode <= 1'b1; // RL10
      r.map_en <= 1'b0;
      r.intr_en <= 1'b0;
      r.exception_return_address <= `PMD_EXC_RST;
      r.privileged_code_base <= `PMD_BASE_RST; // RL21
      r.pend <= 6'h00;
      r.off <= `PMD_OFF_RESET;
      r.save_pc <= `PMD_EXC_RST;
      r.from_instr <= 1'b0;
      r.drain <= 1'b0;
      r.redirect <= 1'b0;
      r.redirect_pc <= `PMD_EXC_RST;
      r.trap <= 1'b0;
      r.unmapped <= 1'b0;
      r.rdata <= 64'h0000_0000_0000_0000;
      r.ready <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign INSTR_READY = r.ready;
  assign PRIV_MODE = r.privileged_code_mode;
  assign FETCH_MAP_EN = r.map_en;
  assign INTR_ENABLE = r.intr_en;
  assign DRAIN_REQ = r.drain;
  assign REDIRECT_VALID = r.redirect;
  assign REDIRECT_PC = r.redirect_pc;
  assign TRAP_ILLEGAL_OPCODE_TRAP = r.trap;
  assign UNMAPPED_ACCESS = r.unmapped;
  assign IPR_RDATA = r.rdata;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_map_off: assert property (PRIV_MODE |-> !FETCH_MAP_EN) // RL1
    else $error("Fetch mapping enabled in privileged mode");

  chk_intr_held: assert property (PRIV_MODE |-> !INTR_ENABLE) // RL2
    else $error("Interrupts enabled in privileged mode");

  chk_hw_outside: assert property (acc && is_hw && !PRIV_MODE // RL3
    |=> TRAP_ILLEGAL_OPCODE_TRAP && DRAIN_REQ
    ##[1:300] REDIRECT_VALID && REDIRECT_PC[13:0] == `PMD_OFF_ILLEGAL_OPCODE_TRAP)
    else $error("Privileged-only instruction outside mode not trapped");

  chk_unmapped_op: assert property (acc && (is_ld || is_st) && PRIV_MODE |=> UNMAPPED_ACCESS) // RL4
    else $error("Special load or store not flagged as unmapped");

  chk_disp_addr: assert property (r.state == PMD_ST_DISP |=> REDIRECT_VALID // RL5
    && REDIRECT_PC == {$past(r.privileged_code_base), $past(r.off)} && PRIV_MODE)
    else $error("Dispatch address or mode wrong");

  chk_drain_order: assert property (r.state == PMD_ST_DRAIN && PIPE_EMPTY // RL6
    |=> !REDIRECT_VALID && r.exception_return_address == $past(r.from_instr ? r.save_pc : CUR_PC)
    ##1 REDIRECT_VALID && PRIV_MODE)
    else $error("Save and dispatch out of order");

  chk_no_early_jump: assert property (DRAIN_REQ && !PIPE_EMPTY |=> !REDIRECT_VALID) // RL6
    else $error("Dispatch before pipeline drained");

  chk_return_jump: assert property (acc && is_rei && PRIV_MODE |=> REDIRECT_VALID // RL7
    && REDIRECT_PC == {$past(r.exception_return_address[33:2]), 2'b00}
    && PRIV_MODE == $past(r.exception_return_address[0]))
    else $error("Return target or mode wrong");

  chk_return_leave: assert property (acc && is_rei && PRIV_MODE // RL9
    && !r.exception_return_address[0] |=> FETCH_MAP_EN && INTR_ENABLE)
    else $error("Leaving privileged mode did not re-enable");

  chk_reset_entry: assert property (r.state == PMD_ST_RESET // RL10
    |=> PRIV_MODE && REDIRECT_VALID && REDIRECT_PC[13:0] == `PMD_OFF_RESET)
    else $error("Reset did not enter privileged mode at reset entry");

  chk_call_save: assert property (acc && is_call && !illegal // RL15
    |=> r.save_pc == $past(INSTR_PC) + `PMD_CALL_STEP && r.off == $past(call_off))
    else $error("Call saved wrong return address");

  chk_priv_call: assert property (acc && is_call && call_priv && call_ok && !KERNEL_MODE // RL17
    && !PRIV_MODE |=> TRAP_ILLEGAL_OPCODE_TRAP && r.off == `PMD_OFF_ILLEGAL_OPCODE_TRAP)
    else $error("Privileged call outside kernel not trapped");

  chk_one_cause: assert property (take_evt && ($countones(r.pend) > 1) // RL22
    |=> r.pend != 6'h00 && r.state == PMD_ST_DRAIN)
    else $error("Lower priority cause lost");

  // Entry checks use the fixed offsets, so a broken selector cannot hide
  chk_machine_check_entry_first: assert property (take_evt && r.pend[PMD_EV_MACHINE_CHECK_ENTRY] // RL11
    |=> r.off == `PMD_OFF_MACHINE_CHECK_ENTRY)
    else $error("Machine check not served first");

  chk_intr_entry: assert property (take_evt && r.pend[PMD_EV_INTR] // RL12
    && r.pend[1:0] == 2'b00 |=> r.off == `PMD_OFF_INTR)
    else $error("Interrupt not sent to its routine");

  chk_itb_entry: assert property (take_evt && r.pend == 6'h10 // RL13
    |=> r.off == `PMD_OFF_ITB_MISS)
    else $error("Instruction miss not sent to its fill routine");

  chk_dtb_entry: assert property (take_evt && r.pend == 6'h20 // RL13
    |=> r.off == `PMD_OFF_DTB_MISS)
    else $error("Data miss not sent to its fill routine");

  chk_call_drain: assert property (acc && is_call // RL14
    |=> DRAIN_REQ && !INSTR_READY && r.state == PMD_ST_DRAIN)
    else $error("Call did not start a drain");

  chk_call_func: assert property (acc && is_call && !illegal // RL16
    |=> r.off[11:0] == {$past(INSTR_WORD[5:0]), 6'h00}
    && r.off[13:12] == ($past(INSTR_WORD[7]) ? 2'b11 : 2'b10))
    else $error("Call entry not taken from function field");

  chk_bad_call: assert property (acc && INSTR_WORD[31:26] == `PMD_OP_CALL // RL18
    && (INSTR_WORD[25:8] != 18'h0_0000 || INSTR_WORD[6]) |=> TRAP_ILLEGAL_OPCODE_TRAP)
    else $error("Unsupported call function not trapped");

  chk_call_priv: assert property (acc && is_call && !illegal |=> DRAIN_REQ // RL19
    ##[1:300] REDIRECT_VALID && PRIV_MODE && !FETCH_MAP_EN && !INTR_ENABLE)
    else $error("Called routine not run in privileged mode");

  chk_base_reset: assert property ($fell(RST) |-> r.privileged_code_base == 20'h0_0000) // RL21
    else $error("Base not zero after reset");

  chk_base_write: assert property (acc && is_mtpr && ibx_base && PRIV_MODE // RL4
    |=> r.privileged_code_base == $past(IPR_WDATA[33:14]))
    else $error("Base register write lost");

  cov_event_disp: cover property (take_evt ##[1:20] REDIRECT_VALID);
  cov_call_disp: cover property (acc && is_call && !illegal ##[1:20] REDIRECT_VALID);
  cov_return_leave: cover property (acc && is_rei && PRIV_MODE ##1 !PRIV_MODE);
  cov_trap: cover property (TRAP_ILLEGAL_OPCODE_TRAP);
  cov_held_cause: cover property (take_evt && $countones(r.pend) > 1);
endmodule
`default_nettype wire

// file: pmd_pipe_model.sv
// Behavioural model of the pipeline that faces the dispatch unit.
// Assumes the unit raises drain_req and waits for pipe_empty; the model
// stalls a random 0..3 cycles before reporting the pipeline drained.
`timescale 1ns/1ns
`default_nettype none

module pmd_pipe_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Drain handshake
  input wire logic drain_req,
  output logic pipe_empty,
  // Current program counter
  output logic [33:0] cur_pc
);
  logic [1:0] stall;

  // Pc frozen while draining, so the saved value is well defined
  always @(negedge clk) begin
    if (rst) begin
      pipe_empty <= 1'b0;
      stall <= 2'h0;
      cur_pc <= 34'h0_0000_1000;
    end else if (drain_req !== 1'b1) begin
      pipe_empty <= 1'b0;
      stall <= 2'($urandom_range(3, 0));
      cur_pc <= cur_pc + {28'h000_0000, 4'($urandom_range(15, 1)), 2'b00};
    end else if (stall == 2'h0) begin
      pipe_empty <= 1'b1;
    end else begin
      stall <= stall - 2'h1;
    end
  end
endmodule

`default_nettype wire

// file: privileged_mode_dispatch_unit_test.sv
// Self-checking testbench for the privileged mode dispatch unit.
// Assumes pmd_pipe_model answers the drain handshake; inputs change at negedge.
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defines.svh"

module privileged_mode_dispatch_unit_test
  import pmd_pkg::*;
;
  logic CLK, RST, KERNEL_MODE, INSTR_VALID, PIPE_EMPTY;
  logic [5:0] evt;
  logic [31:0] INSTR_WORD;
  logic [33:0] INSTR_PC, CUR_PC, REDIRECT_PC;
  logic [63:0] IPR_WDATA, IPR_RDATA;
  logic INSTR_READY, PRIV_MODE, FETCH_MAP_EN, INTR_ENABLE, DRAIN_REQ;
  logic REDIRECT_VALID, TRAP_ILLEGAL_OPCODE_TRAP, UNMAPPED_ACCESS;
  int n_fail, n_compared;
  logic [33:0] exp_pc[$];
  logic exp_priv[$];
  logic [19:0] base;
  logic [33:0] exc, pc;
  logic trap, unm;
  logic [5:0] ops[5];
  logic [25:0] cf[5];
  logic ck[5];

  pmd_unit i_dut (.CLK(CLK), .RST(RST), .EVT_MACHINE_CHECK_ENTRY(evt[0]), .EVT_ARITH(evt[1]),
    .EVT_INTR(evt[2]), .EVT_DFAULT(evt[3]), .EVT_ITB_MISS(evt[4]),
    .EVT_DTB_MISS(evt[5]), .CUR_PC(CUR_PC), .PIPE_EMPTY(PIPE_EMPTY),
    .KERNEL_MODE(KERNEL_MODE), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
    .INSTR_PC(INSTR_PC), .IPR_WDATA(IPR_WDATA), .INSTR_READY(INSTR_READY),
    .PRIV_MODE(PRIV_MODE), .FETCH_MAP_EN(FETCH_MAP_EN), .INTR_ENABLE(INTR_ENABLE),
    .DRAIN_REQ(DRAIN_REQ), .REDIRECT_VALID(REDIRECT_VALID), .REDIRECT_PC(REDIRECT_PC),
    .TRAP_ILLEGAL_OPCODE_TRAP(TRAP_ILLEGAL_OPCODE_TRAP), .UNMAPPED_ACCESS(UNMAPPED_ACCESS), .IPR_RDATA(IPR_RDATA));

  pmd_pipe_model i_pipe (.clk(CLK), .rst(RST), .drain_req(DRAIN_REQ),
    .pipe_empty(PIPE_EMPTY), .cur_pc(CUR_PC));

  task report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  function automatic logic [13:0] off_of(input int i);
    case (i)
      0: return `PMD_OFF_MACHINE_CHECK_ENTRY;
      1: return `PMD_OFF_ARITH;
      2: return `PMD_OFF_INTR;
      3: return `PMD_OFF_DFAULT;
      4: return `PMD_OFF_ITB_MISS;
      default: return `PMD_OFF_DTB_MISS;
    endcase
  endfunction

  function automatic logic [33:0] rpc();
    logic [31:0] w;
    w = $urandom();
    return {2'b00, w[31:2], 2'b00};
  endfunction

  function automatic logic [31:0] ipr(input logic [5:0] op, input logic [4:0] idx);
    return {op, 18'h0_0000, 3'b001, idx};
  endfunction

  task expect_at(input logic [33:0] p, input logic priv);
    exp_pc.push_back(p);
    exp_priv.push_back(priv);
  endtask

  task send(input logic [31:0] w, input logic [33:0] p);
    int i;
    @(negedge CLK);
    INSTR_WORD = w;
    INSTR_PC = p;
    INSTR_VALID = 1'b1;
    for (i = 0; i < 40 && INSTR_READY !== 1'b1; i++) @(negedge CLK);
    if (i == 40) begin
      n_fail++;
      report_and_stop();
    end
    @(negedge CLK);
    trap = TRAP_ILLEGAL_OPCODE_TRAP;
    unm = UNMAPPED_ACCESS;
    INSTR_VALID = 1'b0;
  endtask

  task wait_idle();
    int i;
    for (i = 0; i < 80 && exp_pc.size() != 0; i++) @(negedge CLK);
    if (i == 80) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task set_exc(input logic [33:0] v);
    IPR_WDATA = {30'h0000_0000, v};
    send(ipr(`PMD_OP_MTPR, `PMD_IPR_EXCEPTION_RETURN_ADDRESS), rpc());
  endtask

  task read_exc(input logic [33:0] v);
    send(ipr(`PMD_OP_MFPR, `PMD_IPR_EXCEPTION_RETURN_ADDRESS), rpc());
    check(IPR_RDATA[33:0] === v, "saved exception address");
  endtask

  // Return with a given target and mode bit; bit 1 is left set on purpose
  task ret(input logic [33:0] t, input logic stay);
    set_exc({t[33:1], stay});
    expect_at({t[33:2], 2'b00}, stay);
    send({`PMD_OP_REI, 10'h3FF, 2'b10, 14'h0000}, rpc());
    check(trap === 1'b0, "return trapped in privileged mode");
    wait_idle();
  endtask

  task pulse(input logic [5:0] m);
    int i;
    @(negedge CLK);
    evt = m;
    @(negedge CLK);
    evt = 6'h00;
    check(INSTR_READY === 1'b0, "ready while cause pending");
    for (i = 0; i < 40 && DRAIN_REQ !== 1'b1; i++) @(negedge CLK);
    if (i == 40) begin
      n_fail++;
      report_and_stop();
    end
    exc = CUR_PC;
  endtask

  // Scoreboard: each redirect is matched against the oldest note
  always @(negedge CLK) begin
    if (RST === 1'b0 && REDIRECT_VALID === 1'b1) begin
      if (exp_pc.size() == 0) begin
        check(1'b0, "redirect with nothing expected");
      end else begin
        check(REDIRECT_PC === exp_pc[0], "redirect target");
        check(PRIV_MODE === exp_priv[0], "mode after redirect");
        check(FETCH_MAP_EN === !exp_priv[0], "fetch mapping enable");
        check(INTR_ENABLE === !exp_priv[0], "interrupt enable");
        void'(exp_pc.pop_front());
        void'(exp_priv.pop_front());
      end
    end
  end

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    void'($urandom(11114));
    RST = 1'b1;
    evt = 6'h00;
    KERNEL_MODE = 1'b0;
    INSTR_VALID = 1'b0;
    INSTR_WORD = 32'h0000_0000;
    INSTR_PC = 34'h0_0000_0000;
    IPR_WDATA = 64'h0000_0000_0000_0000;
    n_fail = 0;
    n_compared = 0;
    base = `PMD_BASE_RST;
    ops = '{`PMD_OP_MFPR, `PMD_OP_LD, `PMD_OP_MTPR, `PMD_OP_REI, `PMD_OP_ST};
    cf = '{26'h000_0083, 26'h000_0005, 26'h000_0005, 26'h000_0100, 26'h000_0045};
    ck = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    expect_at({base, `PMD_OFF_RESET}, 1'b1);
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    wait_idle();
    read_exc(`PMD_EXC_RST);
    base = 20'($urandom());
    IPR_WDATA = {30'h0000_0000, base, 14'h0000};
    send(ipr(`PMD_OP_MTPR, `PMD_IPR_BASE), rpc());
    for (int i = 1; i < 5; i += 3) begin
      send({ops[i], 26'h000_0000}, rpc());
      check(unm === 1'b1 && trap === 1'b0, "unmapped access in mode");
    end
    ret(rpc() | 34'h0_0000_0002, 1'b1);
    ret(rpc() | 34'h0_0000_0002, 1'b0);
    foreach (ops[i]) begin
      pc = rpc();
      expect_at({base, `PMD_OFF_ILLEGAL_OPCODE_TRAP}, 1'b1);
      send({ops[i], 26'h000_0000}, pc);
      check(trap === 1'b1, "privileged-only op outside mode");
      wait_idle();
      read_exc(pc);
      ret(rpc(), 1'b0);
    end
    foreach (cf[i]) begin
      pc = rpc();
      KERNEL_MODE = ck[i];
      if (i == 0) expect_at({base, `PMD_OFF_CALL_USER + {cf[i][5:0], 6'h00}}, 1'b1);
      else if (i == 1) expect_at({base, `PMD_OFF_CALL_PRIV + {cf[i][5:0], 6'h00}}, 1'b1);
      else expect_at({base, `PMD_OFF_ILLEGAL_OPCODE_TRAP}, 1'b1);
      send({`PMD_OP_CALL, cf[i]}, pc);
      check(trap === (i > 1), "call trap flag");
      wait_idle();
      read_exc(i > 1 ? pc : pc + `PMD_CALL_STEP);
      ret(rpc(), 1'b0);
    end
    KERNEL_MODE = 1'b0;
    for (int i = 0; i < 6; i++) begin
      expect_at({base, off_of(i)}, 1'b1);
      pulse(6'h01 << i);
      wait_idle();
      read_exc(exc);
      ret(rpc(), 1'b0);
    end
    expect_at({base, `PMD_OFF_MACHINE_CHECK_ENTRY}, 1'b1);
    pulse(6'h21);
    wait_idle();
    @(negedge CLK);
    evt = 6'h04;
    @(negedge CLK);
    evt = 6'h00;
    repeat (6) @(negedge CLK);
    check(DRAIN_REQ === 1'b0 && PRIV_MODE === 1'b1, "event taken in mode");
    ret(rpc(), 1'b0);
    expect_at({base, `PMD_OFF_INTR}, 1'b1);
    wait_idle();
    // Miss still held while the interrupt routine runs
    ret(rpc(), 1'b0);
    expect_at({base, `PMD_OFF_DTB_MISS}, 1'b1);
    wait_idle();
    report_and_stop();
  end
endmodule

`default_nettype wire
